// >>> imd_pkg.sv
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// shared constants and types of the internal memory address decoder
package imd_pkg;

  // requester ports, lower index wins arbitration
  localparam int IMD_CORE_DATA_MEMORY_BUS = 0;    // data_memory_path, 64 bit
  localparam int IMD_CORE_PROGRAM_MEMORY_BUS = 1; // program_memory_path, 64 bit
  localparam int IMD_PERIPHERAL_DMA_BUS = 2;      // 32 bit
  localparam int IMD_EXTERNAL_PORT_DMA_BUS = 3;   // 32 bit
  localparam int IMD_PORTS = 4;
  localparam int IMD_BLOCKS = 4;

  // widths
  localparam int IMD_ADDR_W = 21;  // word addresses up to the top of the short view
  localparam int IMD_DATA_W = 64;  // core bus width
  localparam int IMD_DMA_HW = 2;   // half-words carried by a 32-bit dma bus
  localparam int IMD_LO_W = 18;    // in-view offset field
  localparam int IMD_HOFF_W = 16;  // half-word offset inside a block
  localparam int IMD_PERIPH_W = 18; // register region offset
  localparam int IMD_IDX_W = 6;    // storage index bits per block
  localparam int IMD_DEPTH = 64;   // half-words stored per block

  // view boundaries
  localparam logic [IMD_ADDR_W-1:0] IMD_PERIPH_END = 21'h03ffff;
  localparam logic [IMD_ADDR_W-1:0] IMD_MID_BASE = 21'h080000;   // 48-bit and normal views
  localparam logic [IMD_ADDR_W-1:0] IMD_SHORT_BASE = 21'h100000;

  // sram bounds inside one block's slice of each view; blocks 0/1 hold rom below the start
  localparam logic [IMD_LO_W-1:0] IMD_LONG_SRAM_LO = 18'h0c000;
  localparam logic [IMD_LO_W-1:0] IMD_LONG_SRAM_HI = 18'h0efff;
  localparam logic [IMD_LO_W-1:0] IMD_LONG_UPPER_HI = 18'h00fff;
  localparam logic [IMD_LO_W-1:0] IMD_EXT_SRAM_LO = 18'h10000;
  localparam logic [IMD_LO_W-1:0] IMD_EXT_SRAM_HI = 18'h13fff;
  localparam logic [IMD_LO_W-1:0] IMD_EXT_UPPER_HI = 18'h01554;
  localparam logic [IMD_LO_W-1:0] IMD_NORM_SRAM_LO = 18'h18000;
  localparam logic [IMD_LO_W-1:0] IMD_NORM_SRAM_HI = 18'h1dfff;
  localparam logic [IMD_LO_W-1:0] IMD_NORM_UPPER_HI = 18'h01fff;
  localparam logic [IMD_LO_W-1:0] IMD_SHORT_SRAM_LO = 18'h30000;
  localparam logic [IMD_LO_W-1:0] IMD_SHORT_SRAM_HI = 18'h3bfff;
  localparam logic [IMD_LO_W-1:0] IMD_SHORT_UPPER_HI = 18'h03fff;

  // what an address lands on
  typedef enum logic [1:0] {
    IMD_TGT_PERIPH = 2'b00,
    IMD_TGT_SRAM = 2'b01,
    IMD_TGT_ROM = 2'b10,
    IMD_TGT_RESV = 2'b11
  } imd_kind_e;

  // access width picked by the view
  typedef enum logic [1:0] {
    IMD_W16 = 2'b00,
    IMD_W32 = 2'b01,
    IMD_W48 = 2'b10,
    IMD_W64 = 2'b11
  } imd_width_e;

  // one request, held until acknowledged
  typedef struct packed {
    logic valid;
    logic write;
    logic ext48;  // selects the 48-bit view where it overlaps the normal view
    logic [IMD_ADDR_W-1:0] addr;
    logic [IMD_DATA_W-1:0] wdata;
  } imd_req_s;

  // one answer, ack is a one-cycle pulse
  typedef struct packed {
    logic ack;
    logic err;
    logic [IMD_DATA_W-1:0] rdata;
  } imd_rsp_s;

  // access forwarded to the register region
  typedef struct packed {
    logic valid;
    logic write;
    logic [IMD_PERIPH_W-1:0] addr;
    logic [IMD_DATA_W-1:0] wdata;
  } imd_periph_s;

  // decoded address
  typedef struct packed {
    imd_kind_e kind;
    logic [1:0] blk;
    imd_width_e width;
    logic [IMD_HOFF_W-1:0] hoff;
  } imd_dec_s;

endpackage
`default_nettype wire

// >>> imd_addr_map.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// combinational map from a word address to target, block, width and offset
module imd_addr_map (
  input wire logic [imd_pkg::IMD_ADDR_W-1:0] addr_i,
  input wire logic ext48_i,
  output var imd_pkg::imd_dec_s dec_o
);
  import imd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // view select, then bounds check inside the block slice
  always_comb begin
    logic [IMD_LO_W-1:0] lo;       // offset inside the block slice
    logic [IMD_LO_W-1:0] sram_lo;  // sram start for blocks 0/1
    logic [IMD_LO_W-1:0] sram_hi;  // sram end for blocks 0/1
    logic [IMD_LO_W-1:0] upper_hi; // sram end for blocks 2/3
    logic [IMD_LO_W-1:0] off;      // word offset inside the sram
    lo = '0;
    sram_lo = IMD_LONG_SRAM_LO;
    sram_hi = IMD_LONG_SRAM_HI;
    upper_hi = IMD_LONG_UPPER_HI;
    off = '0;
    dec_o = '0;
    if (addr_i <= IMD_PERIPH_END) begin
      // register region, never a block
      dec_o.kind = IMD_TGT_PERIPH; // see RULE1
    end else begin
      if (addr_i < IMD_MID_BASE) begin
        // long view, 64-bit words
        dec_o.blk = addr_i[17:16];
        lo = {2'b00, addr_i[15:0]};
        dec_o.width = IMD_W64; // see RULE10
      end else if (addr_i < IMD_SHORT_BASE && ext48_i) begin
        // 48-bit view
        dec_o.blk = addr_i[18:17];
        lo = {1'b0, addr_i[16:0]};
        sram_lo = IMD_EXT_SRAM_LO;
        sram_hi = IMD_EXT_SRAM_HI;
        upper_hi = IMD_EXT_UPPER_HI;
        dec_o.width = IMD_W48; // see RULE10
      end else if (addr_i < IMD_SHORT_BASE) begin
        // normal view, 32-bit words
        dec_o.blk = addr_i[18:17];
        lo = {1'b0, addr_i[16:0]};
        sram_lo = IMD_NORM_SRAM_LO;
        sram_hi = IMD_NORM_SRAM_HI;
        upper_hi = IMD_NORM_UPPER_HI;
        dec_o.width = IMD_W32; // see RULE10
      end else begin
        // short view, 16-bit words
        dec_o.blk = addr_i[19:18];
        lo = addr_i[17:0];
        sram_lo = IMD_SHORT_SRAM_LO;
        sram_hi = IMD_SHORT_SRAM_HI;
        upper_hi = IMD_SHORT_UPPER_HI;
        dec_o.width = IMD_W16; // see RULE10
      end
      if (!dec_o.blk[1]) begin
        // blocks 0 and 1: rom, then sram, then reserved
        if (lo < sram_lo) begin
          dec_o.kind = IMD_TGT_ROM; // see RULE6 see RULE7
        end else if (lo <= sram_hi) begin
          dec_o.kind = IMD_TGT_SRAM; // see RULE2 see RULE3
          off = lo - sram_lo;
        end else begin
          dec_o.kind = IMD_TGT_RESV;
        end
      end else if (lo <= upper_hi) begin
        // blocks 2 and 3: sram at the slice bottom
        dec_o.kind = IMD_TGT_SRAM; // see RULE4 see RULE5
        off = lo;
      end else begin
        // everything above blocks 2 and 3
        dec_o.kind = IMD_TGT_RESV; // see RULE8 see RULE9
      end
      // scale the word offset to half-words
      unique case (dec_o.width)
        IMD_W64: dec_o.hoff = {off[13:0], 2'b00};
        IMD_W48: dec_o.hoff = off[15:0] + {off[14:0], 1'b0};
        IMD_W32: dec_o.hoff = {off[14:0], 1'b0};
        IMD_W16: dec_o.hoff = off[15:0];
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> imd_decoder_top.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// Function
// RULE1 - low region goes to peripheral registers
// RULE2 - block 0 sram ranges in four views
// RULE3 - block 1 sram ranges in four views
// RULE4 - block 2 sram ranges in four views
// RULE5 - block 3 sram ranges in four views
// RULE6 - block 0 rom ranges are reserved
// RULE7 - block 1 rom ranges are reserved
// RULE8 - area above block 2 is reserved
// RULE9 - area above block 3 is reserved
// RULE10 - view picks 16, 32, 48 or 64 bits
// RULE11 - sram holds mixed widths up to two megabits; the model stores only 64 half-words per block
// RULE12 - four blocks served at once without conflict
// RULE13 - core buses 64 bit, dma buses 32 bit
// RULE14 - two core and one dma transfer together
// RULE15 - requester spreads code and data over blocks
// RULE16 - core buses on different blocks both complete
// RULE17 - same-block conflicts use fixed priority, loser stalls
// RULE18 - reserved accesses: no write, zero, error
module imd_decoder_top (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire imd_pkg::imd_req_s [imd_pkg::IMD_PORTS-1:0] req_i,
  output var imd_pkg::imd_rsp_s [imd_pkg::IMD_PORTS-1:0] rsp_o,
  output var imd_pkg::imd_periph_s periph_o
);
  import imd_pkg::*;

  // whole state of the block
  typedef struct packed {
    imd_rsp_s [IMD_PORTS-1:0] rsp;                          // answers per port
    imd_periph_s periph;                                    // forwarded register access
    logic [IMD_BLOCKS-1:0][IMD_DEPTH-1:0][15:0] mem;        // half-word storage per block
  } imd_state_s;

  imd_state_s state_reg; // registered state
  imd_state_s state_next; // next state
  imd_dec_s dec_w [IMD_PORTS]; // decoded address per port
  logic [IMD_PORTS-1:0] elig_w; // port has a request not yet answered

  ////////////////////////////////////////////////////////////////////////////////
  // one decoder per requester so all ports decode in parallel
  for (genvar p = 0; p < IMD_PORTS; p++) begin : g_port
    imd_addr_map u_map (
      .addr_i(req_i[p].addr),
      .ext48_i(req_i[p].ext48),
      .dec_o(dec_w[p])
    );
    // a port just acknowledged sits out one cycle so its held request is not taken twice
    assign elig_w[p] = req_i[p].valid && !state_reg.rsp[p].ack;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // arbitration and access for all ports in one cycle
  always_comb begin
    logic [IMD_BLOCKS:0] busy;   // targets already claimed: four blocks and the register region
    logic [2:0] tgt;             // claimed target of this port
    logic claim;                 // access needs an exclusive target
    int nh;                      // half-words moved
    logic [IMD_IDX_W-1:0] idx;   // storage index
    busy = '0;
    tgt = '0;
    claim = 1'b0;
    nh = 0;
    idx = '0;
    state_next = state_reg;
    state_next.rsp = '0;
    state_next.periph.valid = 1'b0;
    // port 0 first, so a lower index wins any conflict
    for (int p = 0; p < IMD_PORTS; p++) begin
      claim = (dec_w[p].kind == IMD_TGT_SRAM) || (dec_w[p].kind == IMD_TGT_PERIPH);
      tgt = (dec_w[p].kind == IMD_TGT_SRAM) ? {1'b0, dec_w[p].blk} : 3'h4;
      if (elig_w[p] && !(claim && busy[tgt])) begin
        // granted; a loser simply stays unanswered and retries next cycle
        state_next.rsp[p].ack = 1'b1; // see RULE17
        if (claim) begin
          // distinct blocks are all served in this same cycle
          busy[tgt] = 1'b1; // see RULE12 see RULE14 see RULE16
        end
        unique case (dec_w[p].kind)
          IMD_TGT_SRAM: begin
            // width from the view, clamped on the 32-bit dma buses
            unique case (dec_w[p].width)
              IMD_W16: nh = 1;
              IMD_W32: nh = 2;
              IMD_W48: nh = 3;
              IMD_W64: nh = 4;
            endcase
            if (p >= IMD_PERIPHERAL_DMA_BUS && nh > IMD_DMA_HW) begin
              nh = IMD_DMA_HW; // see RULE13
            end
            // every location takes any width, half-words packed low first
            for (int k = 0; k < 4; k++) begin
              if (k < nh) begin
                idx = dec_w[p].hoff[IMD_IDX_W-1:0] + k[IMD_IDX_W-1:0]; // see RULE10 see RULE11
                state_next.rsp[p].rdata[16*k +: 16] = state_reg.mem[dec_w[p].blk][idx];
                if (req_i[p].write) begin
                  state_next.mem[dec_w[p].blk][idx] = req_i[p].wdata[16*k +: 16];
                end
              end
            end
          end
          IMD_TGT_PERIPH: begin
            // forward to the register region, reads answer zero here
            state_next.periph.valid = 1'b1; // see RULE1
            state_next.periph.write = req_i[p].write;
            state_next.periph.addr = req_i[p].addr[IMD_PERIPH_W-1:0];
            state_next.periph.wdata = req_i[p].wdata;
            if (p >= IMD_PERIPHERAL_DMA_BUS) begin
              state_next.periph.wdata[IMD_DATA_W-1:32] = '0; // see RULE13
            end
          end
          IMD_TGT_ROM, IMD_TGT_RESV: begin
            // nothing stored, data stays zero, error flagged
            state_next.rsp[p].err = 1'b1; // see RULE18 see RULE6 see RULE7 see RULE8 see RULE9
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // state register, synchronous reset clears storage too
  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from the state register
  assign rsp_o = state_reg.rsp;
  assign periph_o = state_reg.periph;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);

  // port 0 always wins, so its answer follows one cycle later
  periph_route_a: assert property ( // see RULE1
    elig_w[0] && req_i[0].addr <= IMD_PERIPH_END
    |=> periph_o.valid && !rsp_o[0].err && periph_o.addr == $past(req_i[0].addr[IMD_PERIPH_W-1:0]))
    else $error("register region access not forwarded");

  blk0_long_a: assert property ( // see RULE2
    elig_w[0] && req_i[0].addr inside {[21'h04c000:21'h04efff]} |=> rsp_o[0].ack && !rsp_o[0].err)
    else $error("block 0 long sram not served");

  blk1_short_a: assert property ( // see RULE3
    elig_w[0] && req_i[0].addr inside {[21'h170000:21'h17bfff]} |=> rsp_o[0].ack && !rsp_o[0].err)
    else $error("block 1 short sram not served");

  blk2_ext_a: assert property ( // see RULE4
    elig_w[0] && req_i[0].ext48 && req_i[0].addr inside {[21'h0c0000:21'h0c1554]}
    |=> rsp_o[0].ack && !rsp_o[0].err)
    else $error("block 2 48-bit sram not served");

  blk3_norm_a: assert property ( // see RULE5
    elig_w[0] && !req_i[0].ext48 && req_i[0].addr inside {[21'h0e0000:21'h0e1fff]}
    |=> rsp_o[0].ack && !rsp_o[0].err)
    else $error("block 3 normal sram not served");

  rom_error_a: assert property ( // see RULE6
    elig_w[0] && !req_i[0].ext48 && req_i[0].addr inside {[21'h080000:21'h097fff]}
    |=> rsp_o[0].ack && rsp_o[0].err && rsp_o[0].rdata == '0)
    else $error("block 0 rom access not refused");

  rom1_short_a: assert property ( // see RULE7
    elig_w[0] && req_i[0].addr inside {[21'h140000:21'h16ffff]} |=> rsp_o[0].err)
    else $error("block 1 rom access not refused");

  upper_resv_a: assert property ( // see RULE8
    elig_w[0] && req_i[0].addr inside {[21'h184000:21'h1bffff]} |=> rsp_o[0].err && rsp_o[0].rdata == '0)
    else $error("area above block 2 not reserved");

  top_resv_a: assert property ( // see RULE9
    elig_w[0] && req_i[0].addr inside {[21'h071000:21'h07ffff]} |=> rsp_o[0].err)
    else $error("area above block 3 not reserved");

  short_width_a: assert property ( // see RULE10
    elig_w[0] && req_i[0].addr >= IMD_SHORT_BASE |=> rsp_o[0].rdata[IMD_DATA_W-1:16] == '0)
    else $error("short access returned more than 16 bits");

  dma_width_a: assert property ( // see RULE13
    rsp_o[IMD_PERIPHERAL_DMA_BUS].ack |-> rsp_o[IMD_PERIPHERAL_DMA_BUS].rdata[IMD_DATA_W-1:32] == '0)
    else $error("dma bus answered more than 32 bits");

  parallel_four_a: assert property ( // see RULE12 see RULE14 see RULE16
    (&elig_w) && dec_w[0].kind == IMD_TGT_SRAM && dec_w[1].kind == IMD_TGT_SRAM
    && dec_w[2].kind == IMD_TGT_SRAM && dec_w[3].kind == IMD_TGT_SRAM
    && dec_w[0].blk == 2'h0 && dec_w[1].blk == 2'h1 && dec_w[2].blk == 2'h2 && dec_w[3].blk == 2'h3
    |=> rsp_o[0].ack && rsp_o[1].ack && rsp_o[2].ack && rsp_o[3].ack)
    else $error("conflict-free accesses not served together");

  conflict_stall_a: assert property ( // see RULE17
    elig_w[0] && elig_w[1] && dec_w[0].kind == IMD_TGT_SRAM && dec_w[1].kind == IMD_TGT_SRAM
    && dec_w[0].blk == dec_w[1].blk |=> rsp_o[0].ack && !rsp_o[1].ack)
    else $error("same-block conflict not serialised");

  // other ports may legally write other blocks in the same cycle, so only quiet cycles are judged
  resv_nowrite_a: assert property ( // see RULE18
    rsp_o[0].ack && rsp_o[0].err && (!rsp_o[1].ack || rsp_o[1].err)
    && (!rsp_o[2].ack || rsp_o[2].err) && (!rsp_o[3].ack || rsp_o[3].err)
    |-> $stable(state_reg.mem))
    else $error("reserved access changed storage");

  four_way_c: cover property ((&rsp_o[0].ack) && rsp_o[1].ack && rsp_o[2].ack && rsp_o[3].ack);
  conflict_c: cover property (elig_w[1] && !state_next.rsp[1].ack ##[2:4] rsp_o[1].ack);
  error_c: cover property (rsp_o[2].ack && rsp_o[2].err);
  periph_c: cover property (periph_o.valid && periph_o.write);

endmodule
`default_nettype wire

// >>> imd_req_model.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// requester on one port: takes a command, holds it until acked, then releases
module imd_req_model (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic go_i,
  input wire imd_pkg::imd_req_s cmd_i,
  input wire imd_pkg::imd_rsp_s rsp_i,
  output var imd_pkg::imd_req_s req_o,
  output var logic done_o,
  output var imd_pkg::imd_rsp_s got_o
);
  import imd_pkg::*;
  // request stays put until the ack edge; released fields are inverted so stale values never match
  always_ff @(posedge mclk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      req_o <= '0;
      got_o <= '0;
    end else if (req_o.valid && rsp_i.ack) begin
      req_o.valid <= 1'b0;
      req_o.addr <= ~req_o.addr;
      req_o.wdata <= ~req_o.wdata;
      got_o <= rsp_i;
      done_o <= 1'b1;
    end else if (go_i && !req_o.valid) begin
      req_o <= cmd_i;
      req_o.valid <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// >>> testbench.sv
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// four requesters against the decoder, checked against an integer model
module testbench;
  import imd_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [3:0] go = '0; // launch strobe per requester
  imd_req_s [3:0] cmd = '0; // next command per requester
  imd_req_s [IMD_PORTS-1:0] req;
  imd_rsp_s [IMD_PORTS-1:0] rsp;
  imd_rsp_s [3:0] got; // answer captured by each requester
  logic [3:0] done;
  imd_periph_s periph;
  imd_periph_s per_q [$]; // register region accesses in service order
  int fail_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  int launch = 0;
  int lat [4];
  logic [15:0] mem [4][64] = '{default: '0}; // model of the half-word store
  logic [21:0] edges [46] = '{22'h03ffff, 22'h040000, 22'h04bfff, 22'h04c000, 22'h04efff, 22'h04f000,
    22'h050000, 22'h05c000, 22'h05efff, 22'h05f000, 22'h060fff, 22'h061000, 22'h070fff, 22'h071000,
    22'h07ffff, 22'h28ffff, 22'h290000, 22'h293fff, 22'h294000, 22'h2c1554, 22'h2c1555, 22'h2e1555,
    22'h2fffff, 22'h097fff, 22'h098000, 22'h09dfff, 22'h09e000, 22'h0b7fff, 22'h0b8000, 22'h0c1fff,
    22'h0c2000, 22'h0e1fff, 22'h0e2000, 22'h12ffff, 22'h130000, 22'h13bfff, 22'h13c000, 22'h16ffff,
    22'h170000, 22'h17bfff, 22'h17c000, 22'h183fff, 22'h184000, 22'h1c3fff, 22'h1c4000, 22'h1fffff};

  initial forever #4 mclk_i = ~mclk_i;

  imd_decoder_top u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .req_i(req), .rsp_o(rsp), .periph_o(periph));

  for (genvar g = 0; g < 4; g++) begin : g_req
    imd_req_model u_req (.mclk_i(mclk_i), .rst_i(rst_i), .go_i(go[g]), .cmd_i(cmd[g]), .rsp_i(rsp[g]),
      .req_o(req[g]), .done_o(done[g]), .got_o(got[g]));
  end

  ////////////////////////////////////////////////////////////////////////////////
  // cycle count, register region log and hang guard
  always @(posedge mclk_i) begin
    cyc <= cyc + 1;
    if (periph.valid === 1'b1) per_q.push_back(periph);
    if (cyc == 6000) begin
      fail_count++;
      $display("[FAIL] %0t timeout exp %h got %h", $time, 0, cyc);
      give_verdict();
    end
  end

  // reference decode: kind 0 register, 1 sram, 2 rom, 3 reserved
  function automatic void ref_dec(input logic [20:0] a, input logic x48, input int p,
                                  output int kind, output int blk, output int nhw, output int hoff);
    int lo, base, top, mul;
    kind = 1; blk = 0; nhw = 0; hoff = 0; lo = 0; base = 0; top = 0; mul = 1;
    if (a <= 21'h03ffff) begin
      kind = 0;
      return;
    end
    if (a < 21'h080000) begin
      blk = (a >> 16) & 3; lo = a & 'hffff; mul = 4; base = blk < 2 ? 'hc000 : 0; top = blk < 2 ? 'hefff : 'hfff;
    end else if (a < 21'h100000 && x48) begin
      blk = (a >> 17) & 3; lo = a & 'h1ffff; mul = 3; base = blk < 2 ? 'h10000 : 0; top = blk < 2 ? 'h13fff : 'h1554;
    end else if (a < 21'h100000) begin
      blk = (a >> 17) & 3; lo = a & 'h1ffff; mul = 2; base = blk < 2 ? 'h18000 : 0; top = blk < 2 ? 'h1dfff : 'h1fff;
    end else begin
      blk = (a >> 18) & 3; lo = a & 'h3ffff; base = blk < 2 ? 'h30000 : 0; top = blk < 2 ? 'h3bfff : 'h3fff;
    end
    if (lo < base) kind = 2;
    else if (lo > top) kind = 3;
    hoff = (lo - base) * mul;
    nhw = (p >= 2 && mul > 2) ? 2 : mul;
  endfunction

  // sram address of view v (0 long, 1 48-bit, 2 normal, 3 short), block b, offset o
  function automatic logic [20:0] gen(input int v, input int b, input int o);
    case (v)
      0: return 21'(32'h40000 + b * 32'h10000 + (b < 2 ? 32'hc000 : 0) + o);
      1: return 21'(32'h80000 + b * 32'h20000 + (b < 2 ? 32'h10000 : 0) + o);
      2: return 21'(32'h80000 + b * 32'h20000 + (b < 2 ? 32'h18000 : 0) + o);
      default: return 21'(32'h100000 + b * 32'h40000 + (b < 2 ? 32'h30000 : 0) + o);
    endcase
  endfunction

  task automatic chk_rsp(input logic [64:0] exp, input logic [64:0] act);
    cmp_count++;
    if (act !== exp) begin
      fail_count++;
      $display("[FAIL] %0t rsp exp %h got %h", $time, exp, act);
    end
  endtask

  task automatic chk_evt(input logic [95:0] exp, input logic [95:0] act);
    cmp_count++;
    if (act !== exp) begin
      fail_count++;
      $display("[FAIL] %0t event exp %h got %h", $time, exp, act);
    end
  endtask

  // launch the masked requesters together and wait for all answers
  task automatic run(input logic [3:0] m);
    logic [3:0] seen;
    int n;
    seen = '0;
    n = 0;
    @(posedge mclk_i);
    go <= m;
    launch = cyc;
    while (seen != m && n < 30) begin
      @(posedge mclk_i);
      go <= '0;
      for (int p = 0; p < 4; p++) if (m[p] && done[p] === 1'b1 && !seen[p]) begin
        seen[p] = 1'b1;
        lat[p] = cyc - launch;
      end
      n++;
    end
    if (seen != m) begin
      fail_count++;
      $display("[FAIL] %0t ack exp %h got %h", $time, m, seen);
    end
    @(negedge mclk_i);
  endtask

  // compare one port's answer with the model and update the model store
  task automatic judge(input int p);
    int k, b, nh, h;
    logic [63:0] rd;
    imd_periph_s pe;
    ref_dec(cmd[p].addr, cmd[p].ext48, p, k, b, nh, h);
    rd = '0;
    if (k == 1) for (int i = 0; i < nh; i++) begin
      rd[16*i +: 16] = mem[b][(h + i) % 64];
      if (cmd[p].write) mem[b][(h + i) % 64] = cmd[p].wdata[16*i +: 16];
    end
    chk_rsp({k >= 2, rd}, {got[p].err, got[p].rdata});
    if (k == 0) begin
      pe = per_q.size() > 0 ? per_q.pop_front() : '0;
      // forwarded data follows the request, dma ports carry only the low 32 bits
      rd = p >= 2 ? {32'h0, cmd[p].wdata[31:0]} : cmd[p].wdata;
      chk_evt({13'h0, cmd[p].write, cmd[p].addr[17:0], rd}, {13'h0, pe.write, pe.addr, pe.wdata});
    end
  endtask

  // run a batch: latency grows by one per earlier port on the same target
  task automatic go_check(input logic [3:0] m);
    int k, b, nh, h, r;
    int t [4];
    for (int p = 0; p < 4; p++) begin
      ref_dec(cmd[p].addr, cmd[p].ext48, p, k, b, nh, h);
      t[p] = k == 1 ? b : k == 0 ? 4 : 5 + p;
    end
    run(m);
    for (int p = 0; p < 4; p++) if (m[p]) begin
      r = 0;
      for (int q = 0; q < p; q++) if (m[q] && t[q] == t[p]) r++;
      judge(p);
      chk_evt(96'(4 + r), 96'(lat[p]));
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    int v;
    logic [20:0] a;
    void'($urandom(75417));
    repeat (4) @(posedge mclk_i);
    chk_evt('0, 96'({|rsp, |periph}));
    rst_i <= 1'b0;
    $display("test reset done");
    // the 46 listed view and region edges, reads and writes on rotating ports
    for (int i = 0; i < 46; i++) begin
      cmd[i%4] = '{1'b1, 1'(i % 2), edges[i][21], edges[i][20:0], {$urandom, $urandom}};
      go_check(4'(1 << (i % 4)));
    end
    $display("test boundaries done");
    // distinct blocks, one shared block, shared register region
    for (int s = 0; s < 3; s++) begin
      for (int p = 0; p < 4; p++) begin
        a = s == 2 ? 21'(p * 4 + 'h100) : gen(3, s == 1 ? 1 : p, p);
        cmd[p] = '{1'b1, 1'(s), 1'b0, a, {$urandom, $urandom}};
      end
      go_check(4'hf);
    end
    $display("test parallel done");
    // random mixed widths with overlapping offsets across views
    for (int i = 0; i < 100; i++) begin
      for (int p = 0; p < 4; p++) begin
        v = $urandom % 4;
        a = ($urandom % 8 == 0) ? 21'($urandom) : gen(v, $urandom % 4, $urandom % 24);
        cmd[p] = '{1'b1, 1'($urandom), v == 1 ? 1'b1 : v == 2 ? 1'b0 : 1'($urandom), a, {$urandom, $urandom}};
      end
      go_check(4'($urandom_range(15, 1)));
    end
    $display("test random done");
    give_verdict();
  end
endmodule
`default_nettype wire
